// File: bsm_pkg.sv
// Constants and types shared by the core-2/3 status and top mask register block.
// Assumes a register bank that supplies clk, rst and a byte-wide register access port.
//
// Summary of operation
// R1: Bits 7 and 3 show core enable.
// R2: Bits 6 and 2 show raw power-good.
// R3: Bits 4 and 0 show raw current-limit.
// R4: Core-2 enable bit tracks live state, reset 0.
// R5: Mask bit 0 allows, 1 suppresses interrupt.
// R6: Mask bit 2 gates thermal warning, reset 0.
// R7: Thermal mask never alters live thermal status.
// R8: Mask bit 1 gates register reset, reset 1.
// R9: Mask bit 0 gates load-current ready, reset 1.
// R10: Status writes ignored; bits 5,1 read 0.
// R11: Mask bits 7:3 store writes, reset 0.
package bsm_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] CORE23_STATUS_ADDR      = 8'h1d;
  localparam logic [7:0] TOP_INTERRUPT_MASK_ADDR = 8'h1e;

  // ****************************************************************
  // Field positions of the core-2/3 status register
  // ****************************************************************
  localparam int CORE3_ENABLED_BIT           = 7;
  localparam int CORE3_POWER_GOOD_RAW_BIT    = 6;
  localparam int CORE3_CURRENT_LIMIT_RAW_BIT = 4;
  localparam int CORE2_ENABLED_BIT           = 3;
  localparam int CORE2_POWER_GOOD_RAW_BIT    = 2;
  localparam int CORE2_CURRENT_LIMIT_RAW_BIT = 0;

  // ****************************************************************
  // Field positions and reset value of the top interrupt mask register
  // ****************************************************************
  localparam int THERMAL_WARNING_IRQ_MASK_BIT = 2;
  localparam int REGS_RESET_IRQ_MASK_BIT      = 1;
  localparam int ILOAD_READY_IRQ_MASK_BIT     = 0;
  localparam int MASK_SPARE_LSB               = 3;
  localparam logic [7:0] TOP_INTERRUPT_MASK_RESET = 8'h03;

  // Synchroniser depth for inputs from the analogue domain.
  localparam int SYNC_STAGES = 2;

  // Raw condition of one converter core.
  typedef struct packed {
    logic enabled;
    logic power_good_raw;
    logic current_limit_raw;
  } bsm_core_raw_t;

  // Interrupt sources gated by the top mask register.
  typedef struct packed {
    logic thermal_warning;
    logic regs_reset;
    logic iload_ready;
  } bsm_top_event_t;

endpackage

// File: bsm_sync.sv
// Multi-bit two-flop synchroniser, one independent bit per lane.
// Assumes every lane is a slow level that may change at any time.
`timescale 1ns/1ps
`default_nettype none

module bsm_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule

`default_nettype wire

// File: bsm_regs.sv
// Core-2/3 status register and top interrupt mask register of the converter register bank.
// Assumes the serial interface decodes host cycles into a byte-wide read and write port on clk.
`timescale 1ns/1ps
`default_nettype none

module bsm_regs (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Register access port from the serial interface
  input  wire logic [7:0]              reg_addr,
  input  wire logic                    reg_wr_en,
  input  wire logic [7:0]              reg_wr_data,
  input  wire logic                    reg_rd_en,
  output logic      [7:0]              reg_rd_data,
  output logic                         reg_rd_valid,
  // Raw converter core conditions, asynchronous
  input  wire bsm_pkg::bsm_core_raw_t  core2_raw,
  input  wire bsm_pkg::bsm_core_raw_t  core3_raw,
  // Die temperature warning, asynchronous, and its live status
  input  wire logic                    thermal_warning_in,
  output logic                         thermal_warning_live,
  // Interrupt events in and gated interrupt requests out
  input  wire bsm_pkg::bsm_top_event_t top_event,
  output logic                         thermal_warning_irq_req,
  output logic                         regs_reset_irq_req,
  output logic                         iload_ready_irq_req,
  // Current mask bits for the interrupt flag logic
  output logic                         thermal_warning_irq_mask,
  output logic                         regs_reset_irq_mask,
  output logic                         iload_ready_irq_mask
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************

  bsm_pkg::bsm_core_raw_t core2_sync;
  bsm_pkg::bsm_core_raw_t core3_sync;
  logic                   thermal_sync;
  logic [6:0]             sync_bus;

  // All analogue conditions cross into clk through two flops, reset to 0.
  bsm_sync #(
    .WIDTH (7)
  ) u_status_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({core3_raw, core2_raw, thermal_warning_in}),
    .sync_out (sync_bus)
  );

  // The synchronised lanes are split back into their fields.
  assign {core3_sync, core2_sync, thermal_sync} = sync_bus;

  // ****************************************************************
  // Status register image
  // ****************************************************************

  logic [7:0] status_image;

  // Each status bit follows its synchronised condition; reserved bits stay 0.
  always_comb begin
    status_image = 8'h00;                                                                   // [R10]
    status_image[bsm_pkg::CORE3_ENABLED_BIT]           = core3_sync.enabled;                // [R1]
    status_image[bsm_pkg::CORE2_ENABLED_BIT]           = core2_sync.enabled;                // [R1] [R4]
    status_image[bsm_pkg::CORE3_POWER_GOOD_RAW_BIT]    = core3_sync.power_good_raw;         // [R2]
    status_image[bsm_pkg::CORE2_POWER_GOOD_RAW_BIT]    = core2_sync.power_good_raw;         // [R2]
    status_image[bsm_pkg::CORE3_CURRENT_LIMIT_RAW_BIT] = core3_sync.current_limit_raw;      // [R3]
    status_image[bsm_pkg::CORE2_CURRENT_LIMIT_RAW_BIT] = core2_sync.current_limit_raw;      // [R3]
  end

  // ****************************************************************
  // Mask register and read path
  // ****************************************************************

  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic       rd_valid_reg;
  logic       rd_valid_next;

  // Only the mask register takes writes; all eight bits store the host value.
  // A write to the status offset or any other offset changes nothing here.
  always_comb begin
    mask_next = mask_reg;
    if (reg_wr_en && (reg_addr == bsm_pkg::TOP_INTERRUPT_MASK_ADDR)) begin                  // [R10]
      mask_next = reg_wr_data;                                                              // [R11]
    end
  end

  // Reads return the addressed register one cycle later; other offsets read 0.
  always_comb begin
    rd_valid_next = reg_rd_en;
    rd_data_next  = rd_data_reg;
    if (reg_rd_en) begin
      case (reg_addr)
        bsm_pkg::CORE23_STATUS_ADDR:      rd_data_next = status_image;
        bsm_pkg::TOP_INTERRUPT_MASK_ADDR: rd_data_next = mask_reg;
        default:                          rd_data_next = 8'h00;
      endcase
    end
  end

  // Mask resets with thermal unmasked, the other two masked, spare bits 0.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_reg     <= bsm_pkg::TOP_INTERRUPT_MASK_RESET;                                   // [R6] [R8] [R9] [R11]
      rd_data_reg  <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      mask_reg     <= mask_next;
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  assign reg_rd_data  = rd_data_reg;
  assign reg_rd_valid = rd_valid_reg;

  assign thermal_warning_irq_mask = mask_reg[bsm_pkg::THERMAL_WARNING_IRQ_MASK_BIT];
  assign regs_reset_irq_mask      = mask_reg[bsm_pkg::REGS_RESET_IRQ_MASK_BIT];
  assign iload_ready_irq_mask     = mask_reg[bsm_pkg::ILOAD_READY_IRQ_MASK_BIT];

  // ****************************************************************
  // Interrupt gating and live thermal status
  // ****************************************************************

  bsm_pkg::bsm_top_event_t irq_req_reg;
  bsm_pkg::bsm_top_event_t irq_req_next;
  logic                    thermal_live_reg;
  logic                    thermal_live_next;

  // A mask bit of 0 lets its event through, 1 blocks it; the live status ignores the mask.
  always_comb begin
    irq_req_next.thermal_warning = top_event.thermal_warning & ~thermal_warning_irq_mask;   // [R5] [R6]
    irq_req_next.regs_reset      = top_event.regs_reset & ~regs_reset_irq_mask;             // [R5] [R8]
    irq_req_next.iload_ready     = top_event.iload_ready & ~iload_ready_irq_mask;           // [R5] [R9]
    thermal_live_next            = thermal_sync;                                            // [R7]
  end

  // Requests are registered one-cycle copies of the gated events.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_req_reg      <= '0;
      thermal_live_reg <= 1'b0;
    end else begin
      irq_req_reg      <= irq_req_next;
      thermal_live_reg <= thermal_live_next;
    end
  end

  assign thermal_warning_irq_req = irq_req_reg.thermal_warning;
  assign regs_reset_irq_req      = irq_req_reg.regs_reset;
  assign iload_ready_irq_req     = irq_req_reg.iload_ready;
  assign thermal_warning_live    = thermal_live_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (rst);

  // A read of the status offset issued once both synchroniser stages have left reset.
  sequence s_status_read;
    reg_rd_en && (reg_addr == bsm_pkg::CORE23_STATUS_ADDR) && !$past(rst, 1) && !$past(rst, 2);
  endsequence

  // A write of the mask offset.
  sequence s_mask_write;
    reg_wr_en && (reg_addr == bsm_pkg::TOP_INTERRUPT_MASK_ADDR);
  endsequence

  // Enable bits are read back from the raw inputs three edges earlier.
  a_core_enable_read: assert property (                                                     // [R1] [R4]
    s_status_read |=> (reg_rd_data[7] == $past(core3_raw.enabled, 3))
                       && (reg_rd_data[3] == $past(core2_raw.enabled, 3)))
    else $error("core enable bit does not match its input");

  // Power-good bits follow their raw inputs.
  a_power_good_read: assert property (                                                      // [R2]
    s_status_read |=> (reg_rd_data[6] == $past(core3_raw.power_good_raw, 3))
                       && (reg_rd_data[2] == $past(core2_raw.power_good_raw, 3)))
    else $error("power good bit does not match its input");

  // Current-limit bits follow their raw inputs.
  a_current_limit_read: assert property (                                                   // [R3]
    s_status_read |=> (reg_rd_data[4] == $past(core3_raw.current_limit_raw, 3))
                       && (reg_rd_data[0] == $past(core2_raw.current_limit_raw, 3)))
    else $error("current limit bit does not match its input");

  // Reserved status bits read 0 and writes to the status offset leave the mask alone.
  a_status_reserved_zero: assert property (                                                 // [R10]
    s_status_read |=> (reg_rd_data[5] == 1'b0) && (reg_rd_data[1] == 1'b0))
    else $error("reserved status bit reads non-zero");

  a_status_write_ignored: assert property (                                                 // [R10]
    (reg_wr_en && (reg_addr != bsm_pkg::TOP_INTERRUPT_MASK_ADDR)) |=> $stable(mask_reg))
    else $error("mask changed by a write to another offset");

  // A mask write, one idle cycle, then a mask read returns the whole byte, spare bits included.
  a_mask_readback: assert property (                                                        // [R11]
    (s_mask_write ##1 !reg_wr_en ##1 (reg_rd_en && !reg_wr_en
                                      && (reg_addr == bsm_pkg::TOP_INTERRUPT_MASK_ADDR)))
      |=> (reg_rd_data == $past(reg_wr_data, 3)))
    else $error("mask read back differs from value written");

  // Thermal request follows the event only while its mask is 0.
  a_thermal_gate: assert property (                                                         // [R5] [R6]
    top_event.thermal_warning |=> (thermal_warning_irq_req == !$past(mask_reg[2])))
    else $error("thermal warning request not gated by mask");

  // Register reset request is blocked while its mask is 1.
  a_regs_reset_gate: assert property (                                                      // [R8]
    (top_event.regs_reset && regs_reset_irq_mask) |=> !regs_reset_irq_req)
    else $error("register reset request passed a set mask");

  // Load-current request follows the event only while its mask is 0.
  a_iload_gate: assert property (                                                           // [R9]
    top_event.iload_ready |=> (iload_ready_irq_req == !$past(mask_reg[0])))
    else $error("load current ready request not gated by mask");

  // Live thermal status is the input three edges back, whatever the mask.
  a_thermal_live: assert property (                                                         // [R7]
    ##3 (thermal_warning_live == $past(thermal_warning_in, 3)))
    else $error("live thermal status disturbed");

endmodule

`default_nettype wire

// File: bsm_host_model.sv
// Host side model: turns read and write calls into byte strobes on the register port.
// Assumes the block takes a strobe at the rising edge and answers a read one cycle later.
`timescale 1ns/1ps
`default_nettype none

module bsm_host_model (
  // Clock
  input  wire logic       clk,
  // Register access port towards the block
  output logic      [7:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wr_data,
  output logic            reg_rd_en,
  input  wire logic [7:0] reg_rd_data,
  input  wire logic       reg_rd_valid
);
  // ****************************************************************
  // Bus cycles, launched and ended at the falling edge
  // ****************************************************************
  initial begin
    reg_addr    = 8'h00;
    reg_wr_en   = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en   = 1'b0;
  end

  // One write strobe; data is inverted after release so stale data never looks valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr    = a;
    reg_wr_data = d;
    reg_wr_en   = 1'b1;
    @(negedge clk);
    reg_wr_en   = 1'b0;
    reg_wr_data = ~d;
  endtask

  // One read strobe; the answer is taken one cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    d         = reg_rd_data;
    v         = reg_rd_valid;
  endtask
endmodule

`default_nettype wire

// File: buck_status_and_top_mask_regs_tb.sv
// Self-checking bench for the core-2/3 status and top mask registers.
// Assumes bsm_pkg, bsm_regs and bsm_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module buck_status_and_top_mask_regs_tb;
  logic                    clk, rst, wr_en, rd_en, rd_valid, tw_in, tw_live;
  logic                    tw_irq, rr_irq, il_irq, tw_mask, rr_mask, il_mask, v;
  logic [7:0]              addr, wr_data, rd_data, d;
  bsm_pkg::bsm_core_raw_t  c2, c3;
  bsm_pkg::bsm_top_event_t ev;
  int                      fails, total_checks;

  bsm_host_model host (.clk(clk), .reg_addr(addr), .reg_wr_en(wr_en), .reg_wr_data(wr_data),
    .reg_rd_en(rd_en), .reg_rd_data(rd_data), .reg_rd_valid(rd_valid));

  bsm_regs DUT (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wr_en(wr_en), .reg_wr_data(wr_data),
    .reg_rd_en(rd_en), .reg_rd_data(rd_data), .reg_rd_valid(rd_valid), .core2_raw(c2),
    .core3_raw(c3), .thermal_warning_in(tw_in), .thermal_warning_live(tw_live), .top_event(ev),
    .thermal_warning_irq_req(tw_irq), .regs_reset_irq_req(rr_irq), .iload_ready_irq_req(il_irq),
    .thermal_warning_irq_mask(tw_mask), .regs_reset_irq_mask(rr_mask),
    .iload_ready_irq_mask(il_mask));

  // ****************************************************************
  // Checking tasks
  // ****************************************************************
  // Compares one value and counts the outcome.
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // Reads one register and checks the answer marker and the data.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d, v);
    chk("rd_valid", 8'h01, {7'h00, v});
    chk("rd_data", e, d);
  endtask

  // Pulses one event and checks the gated request, then its return to low.
  task automatic ev_chk(input int i, input logic [2:0] e);
    @(negedge clk);
    ev = 3'(1 << i);
    @(negedge clk);
    ev = 3'h0;
    chk("irq_req", {5'h00, e}, {5'h00, tw_irq, rr_irq, il_irq});
    @(negedge clk);
    chk("irq_idle", 8'h00, {5'h00, tw_irq, rr_irq, il_irq});
  endtask

  // Closes the run with the counts and the verdict.
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and test sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Cuts a hang short well after the sequence should have ended.
  initial begin
    #20000;
    fails++;
    give_verdict();
  end

  // Main sequence of register calls with expected values.
  initial begin
    fails = 0;
    total_checks = 0;
    rst = 1'b1;
    tw_in = 1'b0;
    c2 = 3'h0;
    c3 = 3'h0;
    ev = 3'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk("masks", 8'h03, {5'h00, tw_mask, rr_mask, il_mask});
    rd_chk(8'h1e, 8'h03);
    rd_chk(8'h1d, 8'h00);
    // Walks one raw condition at a time through both cores.
    for (int i = 0; i < 6; i++) begin
      c3 = (i < 3) ? 3'(1 << i) : 3'h0;
      c2 = (i < 3) ? 3'h0 : 3'(1 << (i - 3));
      repeat (4) @(negedge clk);
      rd_chk(8'h1d, {c3[2], c3[1], 1'b0, c3[0], c2[2], c2[1], 1'b0, c2[0]});
    end
    c2 = 3'h7;
    c3 = 3'h7;
    repeat (4) @(negedge clk);
    host.wr(8'h1d, 8'h00);
    rd_chk(8'h1d, 8'hdd);
    chk("masks", 8'h03, {5'h00, tw_mask, rr_mask, il_mask});
    rd_chk(8'h1f, 8'h00);
    host.wr(8'h1e, 8'h00);
    for (int i = 0; i < 3; i++) ev_chk(i, 3'(1 << i));
    host.wr(8'h1e, 8'hff);
    rd_chk(8'h1e, 8'hff);
    chk("masks", 8'h07, {5'h00, tw_mask, rr_mask, il_mask});
    for (int i = 0; i < 3; i++) ev_chk(i, 3'h0);
    host.wr(8'h1e, 8'h04);
    rd_chk(8'h1e, 8'h04);
    tw_in = 1'b1;
    repeat (4) @(negedge clk);
    chk("tw_live", 8'h01, {7'h00, tw_live});
    tw_in = 1'b0;
    repeat (4) @(negedge clk);
    chk("tw_live", 8'h00, {7'h00, tw_live});
    // A second reset in mid-run brings the written masks back to their reset values.
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    chk("masks_rst", 8'h03, {5'h00, tw_mask, rr_mask, il_mask});
    @(negedge clk);
    rst = 1'b0;
    rd_chk(8'h1e, 8'h03);
    give_verdict();
  end
endmodule

`default_nettype wire
